//--- common/rsi_pkg.sv
// constants and types shared by the reset, stop and interrupt front end
// assumes one 250 MHz core clock and a plain strobe register port
//
// How it works
// - reset pin forces outputs without clock
// - release waits two clocks, plus pll lock
// - dispatch ten clocks after request recognition
// - stop delay enabled: 25 clocks, line held
// - stop delay disabled: 128K clocks, line held
// - pll stopped in stop adds lock wait
// - pll disabled: no stabilisation wait added
// - general output valid within ten clocks
`default_nettype none
package rsi_pkg;
  // ****************
  // timing
  // ****************
  localparam int CLK_PERIOD_NS  = 4;
  localparam int RESET_LOCK_NS  = 5000000;
  localparam int RESET_LOCK_CYC = (RESET_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_LOCK_NS    = 500000;
  localparam int PLL_LOCK_CYC   = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_LONG_TC   = 131072;
  localparam int STOP_SHORT_TC  = 25;
  localparam int IRQ_LATENCY_TC = 10;
  localparam int TIMER_W        = 21;
  // ****************
  // register map
  // ****************
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  OFS_OPMODE   = 8'h00;
  localparam logic [7:0]  OFS_PLLCTL   = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_CLEAR    = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_EN   = 8'h10;
  localparam logic [7:0]  OFS_STATE    = 8'h14;
  localparam logic [7:0]  OFS_STOP     = 8'h18;
  localparam int          OPM_EDGE_LSB = 0;
  localparam int          OPM_STOP_DLY = 6;
  localparam int          PLL_KEEP_BIT = 12;
  localparam int          PLL_EN_BIT   = 13;
  localparam logic [31:0] OPM_MASK     = 32'h0000004f;
  localparam logic [31:0] PLL_MASK     = 32'h00003000;
  localparam logic [31:0] OPM_RST      = 32'h00000000;
  localparam logic [31:0] PLL_RST      = 32'h00002000;
  // ****************
  // lines and status
  // ****************
  localparam int         NUM_LINES = 5;
  localparam int         NMI_IDX   = 4;
  localparam int         STATUS_W  = 6;
  localparam int         WAKE_BIT  = 5;
  localparam logic [2:0] VEC_NMI   = 3'h4;
  typedef logic [TIMER_W-1:0] count_t;
  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_LOCK  = 5'h02,
    ST_RUN   = 5'h04,
    ST_STOP  = 5'h08,
    ST_WAKE  = 5'h10
  } fsm_e;
endpackage : rsi_pkg
`default_nettype wire

//--- common/timer_if.sv
// load/expire handshake between the front end and its wait timer
// assumes both ends share the core clock
`default_nettype none
interface timer_if;
  import rsi_pkg::*;
  logic   load;
  count_t count;
  logic   expired;
  modport ctrl  (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface : timer_if
`default_nettype wire

//--- core/sync_bank.sv
// two-stage synchronisers for the active-low request pins
// assumes pins are asynchronous to clk; idle level is high
`default_nettype none
module sync_bank
(
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic [rsi_pkg::NUM_LINES-1:0] pin_n,
  output logic      [rsi_pkg::NUM_LINES-1:0] level_n
);
  import rsi_pkg::*;
  typedef struct packed {
    logic [NUM_LINES-1:0] meta;
    logic [NUM_LINES-1:0] stable;
  } sync_s;
  sync_s s_q;
  sync_s s_d;
  // first stage feeds only the second; one-cycle glitches may still pass
  always_comb
  begin
    s_d.meta   = pin_n;
    s_d.stable = s_q.meta;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      s_q <= '1;
    else
      s_q <= s_d;
  end
  assign level_n = s_q.stable;
endmodule : sync_bank
`default_nettype wire

//--- core/cycle_timer.sv
// down counter for the long reset and stop waits
// assumes load is a one-cycle pulse; expired stands until next load
`default_nettype none
module cycle_timer
(
  input wire logic clk,
  input wire logic nrst,
  timer_if.timer   tmr
);
  import rsi_pkg::*;
  typedef struct packed {
    count_t cnt;
    logic   expired;
  } timer_s;
  timer_s s_q;
  timer_s s_d;
  // a load of n gives expired n+1 cycles later, so a wait never runs short
  always_comb
  begin
    s_d = s_q;
    if (tmr.load)
    begin
      s_d.cnt     = tmr.count;
      s_d.expired = 1'b0;
    end
    else
    begin
      if (s_q.cnt != '0)
        s_d.cnt = s_q.cnt - count_t'(1);
      s_d.expired = (s_q.cnt <= count_t'(1));
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      s_q <= '{cnt: '0, expired: 1'b1};
    else
      s_q <= s_d;
  end
  assign tmr.expired = s_q.expired;
endmodule : cycle_timer
`default_nettype wire

//--- core/reset_stop_irq_front_end.sv
// reset release, stop recovery and external request front end
// assumes pins are asynchronous and register port is on clk
//
// Chosen here: the address map and the address-and-strobe port.
`default_nettype none
module reset_stop_irq_front_end
#(
  parameter int unsigned RESET_LOCK_CYCLES = rsi_pkg::RESET_LOCK_CYC,
  parameter int unsigned PLL_LOCK_CYCLES   = rsi_pkg::PLL_LOCK_CYC,
  parameter int unsigned STOP_LONG_CYCLES  = rsi_pkg::STOP_LONG_TC
)
(
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       reset_pin_n,
  input  wire logic                       ext_request_line_a_n,
  input  wire logic                       ext_request_line_b_n,
  input  wire logic                       ext_request_line_c_n,
  input  wire logic                       ext_request_line_d_n,
  input  wire logic                       nonmaskable_req_n,
  input  wire logic [rsi_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [rsi_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [rsi_pkg::DATA_W-1:0] reg_rdata,
  output logic                            irq,
  output logic                            core_reset_n,
  output logic                            pll_power,
  output logic                            in_stop,
  output logic                            dispatch,
  output logic      [2:0]                 dispatch_vector,
  output logic                            gp_out
);
  import rsi_pkg::*;

  // ****************
  // state
  // ****************
  typedef struct packed {
    logic [1:0]           rst_sync;
    fsm_e                 state;
    logic [31:0]          opmode;
    logic [31:0]          pllctl;
    logic [STATUS_W-1:0]  status;
    logic [STATUS_W-1:0]  irq_en;
    logic [NUM_LINES-1:0] prev_n;
    logic [NUM_LINES-1:0] edge_pend;
    logic                 busy;
    logic [3:0]           lat;
    logic [2:0]           vec;
    logic                 dispatch;
    logic                 gp_out;
    logic                 irq;
    logic                 pll_power;
    logic                 core_reset_n;
    logic [31:0]          rdata;
  } core_s;

  localparam core_s CORE_RST = '{
    rst_sync:     2'h0,
    state:        ST_RESET,
    opmode:       OPM_RST,
    pllctl:       PLL_RST,
    status:       '0,
    irq_en:       '0,
    prev_n:       '1,
    edge_pend:    '0,
    busy:         1'b0,
    lat:          4'h0,
    vec:          3'h0,
    dispatch:     1'b0,
    gp_out:       1'b0,
    irq:          1'b0,
    pll_power:    1'b1,
    core_reset_n: 1'b0,
    rdata:        '0
  };

  core_s                s_q;
  core_s                s_d;
  logic [NUM_LINES-1:0] lvl_n;
  logic [NUM_LINES-1:0] edge_mode;
  logic [NUM_LINES-1:0] fall;
  logic [NUM_LINES-1:0] level_req;
  logic [NUM_LINES-1:0] pend;
  logic [STATUS_W-1:0]  clr;
  logic [STATUS_W-1:0]  set;
  logic [2:0]           pick;
  logic                 stop_req;
  logic                 pll_en;
  logic                 pll_off_in_stop;
  count_t               stop_wait;

  timer_if tmr ();

  // ****************
  // helpers
  // ****************
  sync_bank u_sync (
    .clk     (clk),
    .nrst    (nrst),
    .pin_n   ({nonmaskable_req_n, ext_request_line_d_n, ext_request_line_c_n,
               ext_request_line_b_n, ext_request_line_a_n}),
    .level_n (lvl_n)
  );

  cycle_timer u_timer (
    .clk  (clk),
    .nrst (nrst),
    .tmr  (tmr.timer)
  );

  // ****************
  // next state
  // ****************
  always_comb
  begin
    s_d          = s_q;
    tmr.load     = 1'b0;
    tmr.count    = '0;
    clr          = '0;
    stop_req     = 1'b0;
    s_d.dispatch = 1'b0;
    s_d.rdata    = '0;

    pll_en          = s_q.pllctl[PLL_EN_BIT];
    pll_off_in_stop = pll_en && !s_q.pllctl[PLL_KEEP_BIT];
    // lock time is added only when the pll really stopped
    stop_wait = s_q.opmode[OPM_STOP_DLY] ? count_t'(STOP_SHORT_TC)
                                         : count_t'(STOP_LONG_CYCLES);
    if (pll_off_in_stop)
      stop_wait = stop_wait + count_t'(PLL_LOCK_CYCLES);

    // reset pin is released into the core through two flops
    s_d.rst_sync = {s_q.rst_sync[0], 1'b1};

    // nmi is always edge triggered, lines a..d per mode bits
    edge_mode = {1'b1, s_q.opmode[OPM_EDGE_LSB +: 4]};
    fall      = s_q.prev_n & ~lvl_n & edge_mode;
    level_req = ~lvl_n & ~edge_mode;
    s_d.prev_n    = lvl_n;
    s_d.edge_pend = s_q.edge_pend | fall;
    pend          = s_d.edge_pend | level_req;
    set           = {1'b0, fall | level_req};

    // nmi wins, then line a down to line d
    pick = VEC_NMI;
    for (int i = NMI_IDX - 1; i >= 0; i--)
    begin
      if (pend[i])
        pick = 3'(i);
    end
    if (pend[NMI_IDX])
      pick = VEC_NMI;

    // ****************
    // register writes
    // ****************
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_OPMODE: s_d.opmode = reg_wdata & OPM_MASK;
        OFS_PLLCTL: s_d.pllctl = reg_wdata & PLL_MASK;
        OFS_CLEAR:  clr        = reg_wdata[STATUS_W-1:0];
        OFS_IRQ_EN: s_d.irq_en = reg_wdata[STATUS_W-1:0];
        OFS_STOP:   stop_req   = reg_wdata[0];
        default:    ;
      endcase
    end

    // ****************
    // sequencer
    // ****************
    // only one state is ever live; the codes are one-hot so decode is one bit
    unique case (s_q.state)
      ST_RESET:
      begin
        if (s_q.rst_sync[1])
        begin
          if (pll_en)
          begin
            tmr.load  = 1'b1;
            tmr.count = count_t'(RESET_LOCK_CYCLES);
            s_d.state = ST_LOCK;
          end
          else
          begin
            s_d.state        = ST_RUN;
            s_d.core_reset_n = 1'b1;
          end
        end
      end
      ST_LOCK:
      begin
        if (tmr.expired)
        begin
          s_d.state        = ST_RUN;
          s_d.core_reset_n = 1'b1;
        end
      end
      ST_RUN:
      begin
        // stop is refused while a dispatch is in flight
        if (stop_req && !s_q.busy)
        begin
          s_d.state     = ST_STOP;
          s_d.pll_power = !pll_off_in_stop;
        end
      end
      ST_STOP:
      begin
        // line a wakes the core as a level, whatever its mode bit
        if (!lvl_n[0])
        begin
          tmr.load      = 1'b1;
          tmr.count     = stop_wait;
          s_d.state     = ST_WAKE;
          s_d.pll_power = 1'b1;
        end
      end
      ST_WAKE:
      begin
        if (tmr.expired)
        begin
          s_d.state     = ST_RUN;
          // wake status lands as the core resumes, so software sees it at once
          set[WAKE_BIT] = 1'b1;
        end
      end
    endcase

    // ****************
    // dispatch
    // ****************
    // edges that arrive while busy stay latched, one per line
    if (s_q.busy)
    begin
      if (s_q.lat == 4'h0)
      begin
        s_d.dispatch = 1'b1;
        s_d.gp_out   = ~s_q.gp_out;
        s_d.busy     = 1'b0;
      end
      else
        s_d.lat = s_q.lat - 4'h1;
    end
    else if (s_q.state == ST_RUN && !stop_req && |pend)
    begin
      s_d.busy           = 1'b1;
      s_d.lat            = 4'(IRQ_LATENCY_TC - 1);
      s_d.vec            = pick;
      s_d.edge_pend[pick] = 1'b0;
    end

    // a set in the same cycle as its clear wins
    s_d.status = (s_q.status & ~clr) | set;
    s_d.irq    = |(s_d.status & s_d.irq_en);

    // ****************
    // register reads
    // ****************
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_OPMODE: s_d.rdata = s_q.opmode;
        OFS_PLLCTL: s_d.rdata = s_q.pllctl;
        OFS_STATUS: s_d.rdata = 32'(s_q.status);
        OFS_IRQ_EN: s_d.rdata = 32'(s_q.irq_en);
        OFS_STATE:  s_d.rdata = 32'({s_q.gp_out, s_q.busy, s_q.vec, s_q.state});
        default:    s_d.rdata = '0;
      endcase
    end
  end

  // ****************
  // registers
  // ****************
  // the reset pin clears everything at once so outputs need no clock
  // its release reaches every flop at once; rst_sync keeps the sequencer
  // in reset for two more edges so a late-settling flop cannot start it
  always_ff @(posedge clk or negedge reset_pin_n)
  begin
    if (!reset_pin_n)
      s_q <= CORE_RST;
    else if (!nrst)
      s_q <= CORE_RST;
    else
      s_q <= s_d;
  end

  // ****************
  // outputs
  // ****************

  assign reg_rdata       = s_q.rdata;
  assign irq             = s_q.irq;
  assign core_reset_n    = s_q.core_reset_n;
  assign pll_power       = s_q.pll_power;
  assign in_stop         = s_q.state[3];
  assign dispatch        = s_q.dispatch;
  assign dispatch_vector = s_q.vec;
  assign gp_out          = s_q.gp_out;
endmodule : reset_stop_irq_front_end
`default_nettype wire

//--- test/rsi_asserts.sv
// port checks for the reset, stop and request front end
// assumes bind to the top module; sees only its ports
`default_nettype none
module rsi_asserts
#(
  parameter int unsigned RESET_LOCK_CYCLES = 20,
  parameter int unsigned PLL_LOCK_CYCLES   = 10,
  parameter int unsigned STOP_LONG_CYCLES  = 40
)
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       reset_pin_n,
  input wire logic       ext_request_line_a_n,
  input wire logic       ext_request_line_b_n,
  input wire logic       ext_request_line_c_n,
  input wire logic       ext_request_line_d_n,
  input wire logic       nonmaskable_req_n,
  input wire logic       core_reset_n,
  input wire logic       pll_power,
  input wire logic       in_stop,
  input wire logic       dispatch,
  input wire logic [2:0] dispatch_vector,
  input wire logic       gp_out
);
  import rsi_pkg::*;
  // ****************
  // cycle ages
  // ****************
  logic [4:0]  lines_q;
  logic        stop_q;
  logic [15:0] rel_q;
  logic [15:0] trig_q;
  logic [15:0] wake_q;
  wire logic [4:0] lines = {nonmaskable_req_n, ext_request_line_d_n, ext_request_line_c_n,
                            ext_request_line_b_n, ext_request_line_a_n};
  // ages saturate so a long idle run never wraps into a false pass
  always_ff @(posedge clk)
  begin
    lines_q <= lines;
    stop_q  <= in_stop;
    rel_q   <= (!nrst || !reset_pin_n) ? 16'h0 : rel_q + {15'h0, ~&rel_q};
    trig_q  <= !nrst ? 16'hffff : (|(lines_q & ~lines)) ? 16'h0 : trig_q + {15'h0, ~&trig_q};
    wake_q  <= !nrst ? 16'hffff : (stop_q && !in_stop) ? 16'h0 : wake_q + {15'h0, ~&wake_q};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wake_req;
    (in_stop && !ext_request_line_a_n) [*2];
  endsequence
  sequence s_nmi_trig;
    $fell(nonmaskable_req_n) && core_reset_n && !in_stop;
  endsequence
  a_pin_forces: assert property (!reset_pin_n |-> !core_reset_n && !dispatch && pll_power)
    else $error("outputs not at reset level");
  a_release_wait: assert property ($rose(core_reset_n) |-> rel_q >= 16'd2)
    else $error("internal reset left too early");
  a_lock_wait: assert property ($rose(core_reset_n) && pll_power |-> rel_q > RESET_LOCK_CYCLES)
    else $error("internal reset left before lock");
  a_code_latency: assert property (dispatch |-> trig_q >= 16'd9)
    else $error("dispatch too soon after request");
  a_nmi_output: assert property (s_nmi_trig |-> ##[10:15] (dispatch && dispatch_vector == VEC_NMI))
    else $error("nmi not served in time");
  a_gp_toggle: assert property (dispatch |-> gp_out != $past(gp_out))
    else $error("output not changed by dispatch");
  a_wake_quiet: assert property (dispatch |-> wake_q > 16'd25)
    else $error("dispatch before stop recovery");
  a_stop_exit: assert property (s_wake_req |-> ##[1:3] !in_stop)
    else $error("stop not left on line a");
  a_sync_delay: assert property ($fell(ext_request_line_a_n) && in_stop |=> in_stop [*2])
    else $error("line a not synchronised");
  a_pll_hold: assert property (in_stop && $past(in_stop) |-> $stable(pll_power))
    else $error("pll changed inside stop");
  a_pll_back: assert property ($fell(in_stop) |-> pll_power)
    else $error("pll not running at wake");
endmodule : rsi_asserts
`default_nettype wire

//--- test/req_source.sv
// reset driver and request sources facing the front end
// assumes one shared clock; released lines idle high
`default_nettype none
module req_source
(
  input  wire logic       clk,
  output var  logic       reset_pin_n,
  output var  logic [4:0] lines_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    lines_n     = 5'h1f;
    reset_pin_n = 1'b0;
    repeat (2) @(posedge clk);
    reset_pin_n <= 1'b1;
  end
  task automatic pin_reset(input int len);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat ((len < 2) ? 2 : len) @(posedge clk);
    reset_pin_n <= 1'b1;
  endtask : pin_reset
  task automatic pulse(input logic [4:0] m, input int len);
    @(posedge clk);
    lines_n <= lines_n & ~m;
    repeat ((len < 2) ? 2 : len) @(posedge clk);
    lines_n <= lines_n | m;
    repeat ((len < 6) ? 8 - len : 2) @(posedge clk);
  endtask : pulse
  task automatic hold(input logic [4:0] m, input logic lvl);
    @(posedge clk);
    lines_n <= lvl ? (lines_n | m) : (lines_n & ~m);
  endtask : hold
endmodule : req_source
`default_nettype wire

//--- test/reset_stop_irq_front_end_tb.sv
// self-checking bench for the reset, stop and request front end
// assumes req_source drives the pins; short lock and stop counts
`default_nettype none
module reset_stop_irq_front_end_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsi_pkg::*;
  localparam int LOCK  = 20;
  localparam int PLOCK = 10;
  localparam int SLONG = 40;
  logic        clk, nrst, reg_wr, reg_rd, reset_pin_n, irq, core_reset_n;
  logic        pll_power, in_stop, dispatch, gp_out;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [4:0]  lines_n;
  logic [2:0]  dispatch_vector;
  int          checks = 0;
  int          miscompares = 0;
  req_source u_src (.clk(clk), .reset_pin_n(reset_pin_n), .lines_n(lines_n));
  reset_stop_irq_front_end #(.RESET_LOCK_CYCLES(LOCK), .PLL_LOCK_CYCLES(PLOCK),
    .STOP_LONG_CYCLES(SLONG)) dut (.clk(clk), .nrst(nrst), .reset_pin_n(reset_pin_n),
    .ext_request_line_a_n(lines_n[0]), .ext_request_line_b_n(lines_n[1]),
    .ext_request_line_c_n(lines_n[2]), .ext_request_line_d_n(lines_n[3]),
    .nonmaskable_req_n(lines_n[4]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .core_reset_n(core_reset_n), .pll_power(pll_power), .in_stop(in_stop),
    .dispatch(dispatch), .dispatch_vector(dispatch_vector), .gp_out(gp_out));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  // sel 0 core out of reset, 1 dispatch, 2 stop left
  task automatic wait_sig(input int sel, input int lim, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit)
    begin
      @(negedge clk);
      n++;
      hit = (sel == 0) ? core_reset_n === 1'b1 : (sel == 1) ? dispatch === 1'b1 : in_stop === 1'b0;
      if (n >= lim && !hit)
      begin
        miscompares++;
        stop_test();
      end
    end
  endtask : wait_sig
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd
  // irq is registered from the next status and enable values, in step with them
  task automatic irq_is(input logic e);
    @(posedge clk);
    @(negedge clk);
    chk(32'(irq), 32'(e));
  endtask : irq_is
  // ****************
  // scenarios
  // ****************
  task automatic t_reset(input int lo);
    int n;
    wait_sig(0, 4 * LOCK, n);
    chk(32'(n >= lo && n <= LOCK + 10), 32'h1);
  endtask : t_reset
  task automatic t_pin_reset;
    logic [31:0] v;
    rd(OFS_PLLCTL, v);
    chk(v, PLL_RST);
    wr(OFS_STATUS, 32'hff);
    rd(OFS_STATUS, v);
    chk(v | reg_rdata, 32'h0);
    fork
      u_src.pin_reset(2);
    join_none
    @(posedge clk);
    #1;
    chk(32'(core_reset_n), 32'h0);
    chk(32'(pll_power), 32'h1);
    t_reset(LOCK + 4);
  endtask : t_pin_reset
  task automatic t_edges;
    int n;
    logic [31:0] v;
    logic g;
    g = gp_out;
    wr(OFS_OPMODE, 32'h0f);
    wr(OFS_IRQ_EN, 32'h1f);
    for (int i = 0; i < 4; i++)
    begin
      fork
        u_src.pulse(5'(1 << i), 2);
      join_none
      wait_sig(1, 40, n);
      g = ~g;
      chk(32'(n >= 12 && n <= 17), 32'h1);
      chk(32'(dispatch_vector), i);
      chk(32'(gp_out), 32'(g));
      rd(OFS_STATUS, v);
      chk(v, 1 << i);
      irq_is(1'b1);
      wr(OFS_IRQ_EN, 32'h0);
      irq_is(1'b0);
      wr(OFS_IRQ_EN, 32'h1f);
      wr(OFS_CLEAR, 1 << i);
      irq_is(1'b0);
    end
  endtask : t_edges
  task automatic t_priority;
    int n;
    fork
      u_src.pulse(5'h14, 2);
    join_none
    wait_sig(1, 40, n);
    chk(32'(dispatch_vector), 32'(VEC_NMI));
    wait_sig(1, 40, n);
    chk(32'(dispatch_vector), 32'h2);
    chk(32'(n >= 11), 32'h1);
    wr(OFS_CLEAR, 32'h1f);
  endtask : t_priority
  // lines a..d in level mode: one short assertion gives one service
  task automatic t_level;
    int n;
    logic [31:0] v;
    wr(OFS_OPMODE, 32'h0);
    fork
      u_src.pulse(5'h02, 2);
    join_none
    wait_sig(1, 40, n);
    chk(32'(n >= 12 && n <= 17), 32'h1);
    chk(32'(dispatch_vector), 32'h1);
    rd(OFS_STATUS, v);
    chk(v, 32'h2);
    wr(OFS_CLEAR, 32'h1f);
  endtask : t_level
  // the pll-off case stays last: its effect on a running pll is not pinned down
  task automatic t_stop;
    int n;
    int w;
    logic [31:0] v;
    logic [7:0]  opm [4] = '{8'h4f, 8'h0f, 8'h4f, 8'h4f};
    logic [15:0] pll [4] = '{16'h3000, 16'h3000, 16'h2000, 16'h0000};
    for (int i = 0; i < 4; i++)
    begin
      w = (opm[i][6] ? STOP_SHORT_TC : SLONG) + ((pll[i] == 16'h2000) ? PLOCK : 0);
      wr(OFS_OPMODE, 32'(opm[i]));
      wr(OFS_PLLCTL, 32'(pll[i]));
      wr(OFS_STOP, 32'h1);
      @(negedge clk);
      chk(32'(in_stop), 32'h1);
      if (i < 3)
        chk(32'(pll_power), 32'(pll[i] != 16'h2000));
      u_src.hold(5'h01, 1'b0);
      wait_sig(2, 8, n);
      wait_sig(1, w + 40, n);
      chk(32'(n >= w + 10 && n <= w + 16), 32'h1);
      u_src.hold(5'h01, 1'b1);
      rd(OFS_STATUS, v);
      chk(v & 32'h21, 32'h21);
      wr(OFS_CLEAR, 32'h3f);
    end
  endtask : t_stop
  initial
  begin
    nrst      = 1'b0;
    reg_addr  = 8'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset(LOCK + 2);
    t_pin_reset();
    t_edges();
    t_priority();
    t_level();
    t_stop();
    stop_test();
  end
endmodule : reset_stop_irq_front_end_tb
bind reset_stop_irq_front_end rsi_asserts #(.RESET_LOCK_CYCLES(RESET_LOCK_CYCLES),
  .PLL_LOCK_CYCLES(PLL_LOCK_CYCLES), .STOP_LONG_CYCLES(STOP_LONG_CYCLES)) u_chk (
  .clk(clk), .nrst(nrst), .reset_pin_n(reset_pin_n),
  .ext_request_line_a_n(ext_request_line_a_n), .ext_request_line_b_n(ext_request_line_b_n),
  .ext_request_line_c_n(ext_request_line_c_n), .ext_request_line_d_n(ext_request_line_d_n),
  .nonmaskable_req_n(nonmaskable_req_n), .core_reset_n(core_reset_n), .pll_power(pll_power),
  .in_stop(in_stop), .dispatch(dispatch), .dispatch_vector(dispatch_vector), .gp_out(gp_out));
`default_nettype wire
